// ===== hdl/oepv_programmer.sv
// programmer that burns and verifies a 32K x 8 otp eprom
// assumes a host supplies source bytes on request over a ready/valid port
// and external regulators follow the supply request bits
`timescale 1ns/100ps
`include "oepv_defs.svh"
module oepv_programmer
(
   // clock and reset
   input  wire logic                CLOCK,
   input  wire logic                RSTN,
   input  wire logic                CE,
   // command
   input  wire logic                START,
   input  wire logic                ID_REQ,
   input  wire logic                ID_SEL,
   // source data from host
   input  wire logic [7:0]          SRC_DATA,
   input  wire logic                SRC_VALID,
   output logic                     SRC_REQ,
   output logic [14:0]              SRC_ADDR,
   // memory pins
   input  wire logic [7:0]          DATA_IN,
   output oepv_pkg::oepv_pins_t     PINS,
   output oepv_pkg::oepv_supply_t   SUPPLY,
   // results
   output oepv_pkg::oepv_status_t   STATUS,
   output logic [7:0]               ID_CODE
);
   import oepv_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE, S_SUP_CORE, S_SUP_PROG, S_FETCH, S_SETUP, S_PULSE,
      S_GATE, S_SAMPLE, S_FLOAT, S_NEXT, S_LOWER_PROG, S_LOWER_CORE,
      S_RB_FETCH, S_RB_GATE, S_RB_SAMPLE, S_RB_FLOAT, S_SHUT_PROG,
      S_SHUT_CORE, S_ID_SETUP, S_ID_GATE, S_ID_SAMPLE, S_ID_FLOAT
   } oepv_state_t;

   oepv_state_t   state;
   oepv_state_t   next_state;
   logic [16:0]   timer;
   logic [3:0]    retries;
   logic          read_ok;
   logic          result_pass;
   logic [7:0]    expect_byte;
   logic [7:0]    data_s1;
   logic [7:0]    data_s2;
   oepv_pins_t    pins;
   oepv_supply_t  supply;
   oepv_status_t  status;
   logic          src_req;
   logic [7:0]    id_code;

   // all timed waits are whole cycle counts measured by one down-counter
   function automatic logic [16:0] cyc(input int n);
      cyc = 17'(n - 1);
   endfunction

   wire timer_done = (timer == 17'h00000);
   wire byte_ok    = (data_s2 == expect_byte);
   wire last_addr  = (pins.addr == `OEPV_LAST_ADDR);
   wire retry_out  = (retries == `OEPV_MAX_RETRY);

   // ************************************************************
   // pin synchroniser
   // ************************************************************
   // data pins come from an asynchronous part, two flops first
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         data_s1 <= 8'h00;
         data_s2 <= 8'h00;
      end
      else if (CE)
      begin
         data_s1 <= DATA_IN;
         data_s2 <= data_s1;
      end
   end

   // ************************************************************
   // sequencer next state
   // ************************************************************
   // timed states hold until their timer expires, fetch states until SRC_VALID; gate waits cover
   // synchroniser delay on top of the device's data-valid time
   always_comb
   begin
      next_state = state;
      case (state)
         S_IDLE:
            if (START)
               next_state = S_SUP_CORE;
            else if (ID_REQ)
               next_state = S_ID_SETUP;
         S_SUP_CORE:   if (timer_done) next_state = S_SUP_PROG;
         S_SUP_PROG:   if (timer_done) next_state = S_FETCH;
         S_FETCH:      if (SRC_VALID) next_state = S_SETUP;
         S_SETUP:      if (timer_done) next_state = S_PULSE;
         S_PULSE:      if (timer_done) next_state = S_GATE;
         S_GATE:       if (timer_done) next_state = S_SAMPLE;
         S_SAMPLE:     next_state = S_FLOAT;
         S_FLOAT:
            if (timer_done)
            begin
               if (read_ok)
                  next_state = S_NEXT;
               else if (retry_out)
                  next_state = S_SHUT_PROG;
               else
                  next_state = S_SETUP;
            end
         S_NEXT:       next_state = last_addr ? S_LOWER_PROG : S_FETCH;
         S_LOWER_PROG: if (timer_done) next_state = S_LOWER_CORE;
         S_LOWER_CORE: if (timer_done) next_state = S_RB_FETCH;
         S_RB_FETCH:   if (SRC_VALID) next_state = S_RB_GATE;
         S_RB_GATE:    if (timer_done) next_state = S_RB_SAMPLE;
         S_RB_SAMPLE:  next_state = S_RB_FLOAT;
         S_RB_FLOAT:
            if (timer_done)
            begin
               if (!read_ok || last_addr)
                  next_state = S_SHUT_PROG;
               else
                  next_state = S_RB_FETCH;
            end
         S_SHUT_PROG:  if (timer_done) next_state = S_SHUT_CORE;
         S_SHUT_CORE:  if (timer_done) next_state = S_IDLE;
         S_ID_SETUP:   if (timer_done) next_state = S_ID_GATE;
         S_ID_GATE:    if (timer_done) next_state = S_ID_SAMPLE;
         S_ID_SAMPLE:  next_state = S_ID_FLOAT;
         S_ID_FLOAT:   if (timer_done) next_state = S_IDLE;
         default:      next_state = S_IDLE;
      endcase
   end

   wire entering = (next_state != state);

   // ************************************************************
   // state and timer
   // ************************************************************
   // timer reloads on every state change with that state's wait
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state <= S_IDLE;
         timer <= 17'h00000;
      end
      else if (CE)
      begin
         state <= next_state;
         if (entering)
         begin
            case (next_state)
               S_PULSE:
                  timer <= cyc(`OEPV_PULSE_CYC);
               S_GATE, S_RB_GATE, S_ID_GATE:
                  timer <= cyc(`OEPV_GATE_CYC + 2);
               S_FLOAT, S_RB_FLOAT, S_ID_FLOAT:
                  timer <= cyc(`OEPV_FLOAT_CYC);
               default:
                  timer <= cyc(`OEPV_SETUP_CYC);
            endcase
         end
         else if (!timer_done)
            timer <= timer - 17'h00001;
      end
   end

   // ************************************************************
   // pins, supplies and bookkeeping
   // ************************************************************
   // outputs are registered from the state being entered
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pins        <= '{addr: 15'h0000, chip_sel_n: 1'b1, gate_n: 1'b1,
                          id_high_voltage: 1'b0, data_out: 8'h00,
                          data_oe: 1'b0};
         supply      <= '0;
         status      <= '0;
         retries     <= 4'h0;
         read_ok     <= 1'b0;
         result_pass <= 1'b0;
         expect_byte <= 8'h00;
         src_req     <= 1'b0;
         id_code     <= 8'h00;
      end
      else if (CE && entering)
      begin
         pins.chip_sel_n <= 1'b1;
         pins.gate_n     <= 1'b1;
         src_req         <= 1'b0;
         case (next_state)
            S_SUP_CORE:
            begin
               pins.addr     <= 15'h0000;
               status        <= '{busy: 1'b1, default: '0};
               supply        <= '{core_on: 1'b1, core_high: 1'b1,
                                  default: 1'b0};
            end
            S_SUP_PROG:
            begin
               supply.prog_on   <= 1'b1;
               supply.prog_high <= 1'b1;
            end
            S_FETCH:
               src_req <= 1'b1;
            S_RB_FETCH:
            begin
               src_req <= 1'b1;
               if (state == S_RB_FLOAT)
                  pins.addr <= pins.addr + 15'h0001;
            end
            S_SETUP:
            begin
               if (state == S_FETCH)
               begin
                  expect_byte <= SRC_DATA;
                  retries     <= 4'h0;
               end
               else
                  retries <= retries + 4'h1;
               pins.data_out <= (state == S_FETCH) ? SRC_DATA
                                                   : expect_byte;
               pins.data_oe  <= 1'b1;
            end
            S_PULSE:
               pins.chip_sel_n <= 1'b0;
            S_GATE, S_RB_GATE:
            begin
               if (state == S_RB_FETCH)
                  expect_byte <= SRC_DATA;
               pins.data_oe    <= 1'b0;
               pins.chip_sel_n <= 1'b0;
               pins.gate_n     <= 1'b0;
            end
            S_SAMPLE, S_RB_SAMPLE, S_ID_SAMPLE:
            begin
               pins.chip_sel_n <= 1'b0;
               pins.gate_n     <= 1'b0;
            end
            // capture while the gate is still low: output hold after
            // release is not guaranteed, so never decide on float data
            S_FLOAT, S_RB_FLOAT:
               read_ok <= byte_ok;
            S_ID_FLOAT:
               id_code <= data_s2;
            S_NEXT:
               if (!last_addr)
                  pins.addr <= pins.addr + 15'h0001;
            S_LOWER_PROG:
            begin
               pins.data_oe     <= 1'b0;
               supply.prog_high <= 1'b0;
            end
            S_LOWER_CORE:
            begin
               supply.core_high <= 1'b0;
               pins.addr        <= 15'h0000;
            end
            S_SHUT_PROG:
            begin
               // pass only when readback finished clean on last byte
               result_pass   <= (state == S_RB_FLOAT) && read_ok;
               if (state == S_FLOAT)
                  result_pass <= 1'b0;
               pins.data_oe <= 1'b0;
               supply.prog_on   <= 1'b0;
               supply.prog_high <= 1'b0;
            end
            S_SHUT_CORE:
               supply <= '0;
            S_ID_SETUP:
            begin
               pins.id_high_voltage <= 1'b1;
               pins.addr <= {14'h0000, ID_SEL};
               supply    <= '{core_on: 1'b1, default: 1'b0};
               status    <= '{busy: 1'b1, default: '0};
            end
            S_ID_GATE:
            begin
               pins.chip_sel_n <= 1'b0;
               pins.gate_n     <= 1'b0;
            end
            S_IDLE:
            begin
               pins.id_high_voltage <= 1'b0;
               supply    <= '0;
               status    <= '{busy: 1'b0, done: 1'b1,
                              pass: result_pass,
                              fail_addr: pins.addr};
            end
            default:
               pins.data_oe <= pins.data_oe;
         endcase
      end
   end

   assign PINS     = pins;
   assign SUPPLY   = supply;
   assign STATUS   = status;
   assign SRC_REQ  = src_req;
   assign SRC_ADDR = pins.addr;
   assign ID_CODE  = id_code;
endmodule

// ===== shared/oepv_defs.svh
// timing counts and geometry constants for the eprom programmer
// assumes a 100 MHz clock (10 ns period)
`ifndef OEPV_DEFS_SVH
`define OEPV_DEFS_SVH
`define OEPV_CLK_NS        10
`define OEPV_PULSE_NS      100000
`define OEPV_PULSE_CYC     (`OEPV_PULSE_NS / `OEPV_CLK_NS)
`define OEPV_SETUP_NS      2000
`define OEPV_SETUP_CYC     ((`OEPV_SETUP_NS + 9) / 10)
`define OEPV_GATE_NS       150
`define OEPV_GATE_CYC      ((`OEPV_GATE_NS + 9) / 10)
`define OEPV_FLOAT_NS      130
`define OEPV_FLOAT_CYC     ((`OEPV_FLOAT_NS + 9) / 10)
`define OEPV_MAX_RETRY     4'd10
`define OEPV_LAST_ADDR     15'h7FFF
`define OEPV_ID_SEL_BIT    0
`endif

// ===== shared/oepv_pkg.sv
// types shared by the eprom programmer and its bench
// assumes oepv_defs.svh supplies the constants
package oepv_pkg;
   // supply level requests to the external regulators
   typedef enum logic [1:0] {OEPV_SUP_OFF, OEPV_SUP_READ,
                             OEPV_SUP_PROG, OEPV_SUP_ID} oepv_sup_t;
   // memory-side pin bundle driven by the programmer
   typedef struct packed {
      logic [14:0] addr;
      logic        chip_sel_n;
      logic        gate_n;
      logic        id_high_voltage;
      logic [7:0]  data_out;
      logic        data_oe;
   } oepv_pins_t;
   // supply state
   typedef struct packed {
      logic core_on;
      logic core_high;
      logic prog_on;
      logic prog_high;
   } oepv_supply_t;
   // final result
   typedef struct packed {
      logic       busy;
      logic       done;
      logic       pass;
      logic [14:0] fail_addr;
   } oepv_status_t;
endpackage

// ===== verification/oepv_properties.sv
// checker for the eprom programmer pin and supply sequencing
// assumes it is bound to oepv_programmer and sees only its ports
`timescale 1ns/100ps
module oepv_checker
(
   // clock and reset
   input wire logic                  CLOCK,
   input wire logic                  RSTN,
   // memory pins and supplies
   input wire oepv_pkg::oepv_pins_t   PINS,
   input wire oepv_pkg::oepv_supply_t SUPPLY
);
   import oepv_pkg::*;
   int          pw;
   int          gl;
   int          pc;
   logic        last_cs;
   logic [14:0] last_addr;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // pulse length, gate length and pulses spent on this address
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pw <= 0;
         gl <= 0;
         pc <= 0;
         last_cs <= 1'b1;
         last_addr <= 15'h0;
      end
      else
      begin
         pw <= (!PINS.chip_sel_n && PINS.gate_n) ? pw + 1 : 0;
         gl <= PINS.gate_n ? 0 : gl + 1;
         pc <= (PINS.addr != last_addr) ? 0 :
               (last_cs && !PINS.chip_sel_n && PINS.gate_n) ? pc + 1 : pc;
         last_cs <= PINS.chip_sel_n;
         last_addr <= PINS.addr;
      end
   end
   // ************************
   // assertions
   // ************************
   pulse_width_a: assert property (
      pw != 0 && (PINS.chip_sel_n || !PINS.gate_n) |-> pw inside {[9500:10500]})
      else $error("program pulse width out of range");
   prog_start_a: assert property (
      $rose(SUPPLY.prog_high) |-> PINS.addr == 15'h0 && SUPPLY.core_high)
      else $error("program supply raised off first address");
   first_unverified_a: assert property (
      pc == 0 && SUPPLY.prog_high |-> PINS.gate_n)
      else $error("verify read before first pulse");
   retry_limit_a: assert property (
      pc <= 11) else $error("too many pulses on one address");
   addr_step_a: assert property (
      $changed(PINS.addr) && SUPPLY.prog_high |->
         PINS.addr == $past(PINS.addr) + 15'h1)
      else $error("address skipped while programming");
   readback_level_a: assert property (
      !PINS.gate_n && !SUPPLY.prog_high && !PINS.id_high_voltage |->
         !SUPPLY.core_high)
      else $error("read back not at nominal supply");
   gate_hold_a: assert property (
      $rose(PINS.gate_n) |-> gl >= 17)
      else $error("gate released before data valid");
   float_wait_a: assert property (
      $rose(PINS.gate_n) |-> !PINS.data_oe [*8] ##1 !PINS.data_oe [*5])
      else $error("data driven before outputs float");
   core_first_a: assert property (
      SUPPLY.prog_on |-> SUPPLY.core_on)
      else $error("program supply without core supply");
   strobes_a: assert property (
      !PINS.gate_n |-> !PINS.chip_sel_n && !PINS.data_oe)
      else $error("verify read without both strobes");
endmodule
bind oepv_programmer oepv_checker oepv_checker_inst
   (.CLOCK(CLOCK), .RSTN(RSTN), .PINS(PINS), .SUPPLY(SUPPLY));

// ===== verification/oepv_device_model.sv
// behavioural otp eprom answering the programmer's pins
// assumes pins change only on the programmer's clock
`timescale 1ns/100ps
module oepv_device_model
#(
   parameter logic [7:0]  MFR_CODE  = 8'h5A, // arbitrary value
   parameter logic [7:0]  DEV_CODE  = 8'hC3, // arbitrary value
   parameter logic [14:0] WEAK_ADDR = 15'h0000
)
(
   // pins and supplies from the programmer
   input  wire oepv_pkg::oepv_pins_t   pins,
   input  wire oepv_pkg::oepv_supply_t supply,
   // data outputs back
   output logic [7:0]                  data_outputs
);
   import oepv_pkg::*;
   logic [7:0] mem [0:32767];
   logic       weak_hit = 1'b0;
   initial
   begin
      foreach (mem[i]) mem[i] = 8'hFF;
      data_outputs = 8'h00;
   end
   // a pulse burns zeros; the weak cell ignores its first pulse
   always @(negedge pins.chip_sel_n)
   begin
      if (pins.gate_n && supply.prog_high && pins.data_oe)
      begin
         if (pins.addr == WEAK_ADDR && !weak_hit)
            weak_hit = 1'b1;
         else
            mem[pins.addr] = mem[pins.addr] & pins.data_out;
      end
   end
   // garbage until data is valid, so an early sample is caught
   always @(negedge pins.gate_n)
   begin
      data_outputs = ~data_outputs;
      #150;
      if (!pins.gate_n && !pins.chip_sel_n)
         data_outputs = !pins.id_high_voltage ? mem[pins.addr] :
            (pins.addr[0] ? DEV_CODE : MFR_CODE);
   end
   // outputs hold after release, then float to a changed value
   always @(posedge pins.gate_n)
   begin
      #130;
      data_outputs = ~data_outputs;
   end
endmodule

// ===== verification/test_otp_eprom_program_verify.sv
// bench: id reads, first bytes with one weak cell, mid-run reset
// assumes the device model answers on the memory pins
`timescale 1ns/100ps
module test_otp_eprom_program_verify;
   import oepv_pkg::*;
   localparam logic [7:0] MFR = 8'h5A; // arbitrary id value
   localparam logic [7:0] DEV = 8'hC3; // arbitrary id value
   logic         clock = 1'b0;
   logic         rstn = 1'b0;
   logic         start = 1'b0;
   logic         id_req = 1'b0;
   logic         id_sel = 1'b0;
   logic [7:0]   src_data = 8'h00;
   logic         src_valid = 1'b0;
   logic         src_req;
   logic [14:0]  src_addr;
   logic [7:0]   data_in;
   oepv_pins_t   pins;
   oepv_supply_t supply;
   oepv_status_t status;
   logic [7:0]   id_code;
   int           err_total = 0;
   int           comparisons = 0;
   int           pulses [4];
   int           verifies [4];
   int           pw_run = 0;
   int           pw_last = 0;
   logic         prev_cs = 1'b1;
   logic         prev_gate = 1'b1;
   logic [1:0]   id_seen = 2'b00;
   always #5 clock = ~clock;
   oepv_programmer oepv_programmer_inst (.CLOCK(clock), .RSTN(rstn),
      .CE(1'b1), .START(start), .ID_REQ(id_req), .ID_SEL(id_sel),
      .SRC_DATA(src_data), .SRC_VALID(src_valid), .SRC_REQ(src_req),
      .SRC_ADDR(src_addr), .DATA_IN(data_in), .PINS(pins),
      .SUPPLY(supply), .STATUS(status), .ID_CODE(id_code));
   oepv_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) oepv_device_model_inst
      (.pins(pins), .supply(supply), .data_outputs(data_in));
   // ************************
   // source and strobe monitor
   // ************************
   // source byte follows the address, so misplaced bytes show up
   always @(posedge clock)
   begin
      #1;
      src_valid = src_req;
      src_data = src_addr[7:0] ^ 8'h3C;
   end
   // sampled mid-cycle where registered outputs have settled
   always @(negedge clock)
   begin
      if (prev_cs && !pins.chip_sel_n && pins.gate_n)
         pulses[pins.addr[1:0]]++;
      if (prev_gate && !pins.gate_n)
         verifies[pins.addr[1:0]]++;
      if (!pins.gate_n)
         id_seen = {pins.id_high_voltage, pins.addr[0]};
      if (!pins.chip_sel_n && pins.gate_n)
         pw_run++;
      else if (pw_run != 0)
      begin
         pw_last = pw_run;
         pw_run = 0;
      end
      prev_cs = pins.chip_sel_n;
      prev_gate = pins.gate_n;
   end
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] want);
      comparisons++;
      if (seen !== want)
      begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", name, want, seen);
      end
   endtask
   task automatic tick();
      @(posedge clock);
      #1;
   endtask
   task automatic apply_reset();
      rstn = 1'b0;
      repeat (4) tick();
      check("reset_supply", supply, 32'h0);
      check("reset_cs", pins.chip_sel_n, 1'b1);
      rstn = 1'b1;
   endtask
   task automatic run_id(input logic sel, input logic [7:0] want);
      int n;
      tick();
      id_sel = sel;
      id_req = 1'b1;
      tick();
      id_req = 1'b0;
      for (n = 0; status.done !== 1'b1 && n < 2000; n++) tick();
      check("id_done", status.done, 1'b1);
      check("id_code", id_code, want);
      check("id_pins", id_seen, {1'b1, sel});
   endtask
   // address 0 is weak: needs a retry; address 1 takes one pulse
   task automatic run_program();
      int n;
      foreach (pulses[i]) pulses[i] = 0;
      foreach (verifies[i]) verifies[i] = 0;
      tick();
      start = 1'b1;
      tick();
      start = 1'b0;
      for (n = 0; supply.prog_high !== 1'b1 && n < 2000; n++) tick();
      check("prog_high", supply.prog_high, 1'b1);
      check("addr_at_vpp", pins.addr, 15'h0);
      check("core_high", supply.core_high, 1'b1);
      for (n = 0; pins.addr !== 15'h2 && n < 60000; n++) tick();
      check("src_addr", src_addr, 15'h2);
      check("burned0", oepv_device_model_inst.mem[0], 8'h3C);
      check("burned1", oepv_device_model_inst.mem[1], 8'h3D);
      check("weak_pulses", pulses[0], 2);
      check("weak_verifies", verifies[0], 2);
      check("good_pulses", pulses[1], 1);
      check("good_verifies", verifies[1], 1);
      check("pulse_width", pw_last, 10000);
      check("busy", status.busy, 1'b1);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog well beyond the roughly 320 us the tests take
   initial
   begin
      #700000;
      err_total++;
      give_verdict();
   end
   initial
   begin
      apply_reset();
      run_id(1'b0, MFR);
      run_id(1'b1, DEV);
      run_program();
      apply_reset();
      run_id(1'b1, DEV);
      give_verdict();
   end
endmodule
